// [fbd_ctrl.sv]
/*
  Fixed-block disk command controller and its data FIFO.
  Assumes the channel side and the disk formatter run on sys_clk_i; the
  formatter decodes each identification field and checks its check bytes.
*/
`include "fbd_regs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module fbd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module fbd_ctrl
  import fbd_pkg::*;
#(
  parameter int FIFO_DEPTH = `FBD_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Channel command port
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic command_chain_flag_i,
  output logic cmd_ready_o,
  input wire logic param_valid_i,
  input wire logic [7:0] param_byte_i,
  output logic end_valid_o,
  output logic unit_check_o,
  output logic connected_o,
  // Disk positioner and formatter
  output logic seek_req_o,
  output logic [31:0] seek_rba_o,
  input wire logic seek_done_i,
  input wire logic alt_avail_i,
  input wire logic id_valid_i,
  input wire logic id_ok_i,
  input wire logic [31:0] id_rba_i,
  // Data stream through the FIFO
  input wire logic src_valid_i,
  input wire logic [7:0] src_data_i,
  output logic src_ready_o,
  output logic snk_valid_o,
  output logic [7:0] snk_data_o,
  input wire logic snk_ready_i,
  // Status levels
  output logic write_orient_o,
  output logic verify_o,
  output logic replicated_o,
  output logic service_area_o,
  output logic feed_o
);

  state_t state_q;
  cmd_t cur_cmd_q;
  cmd_t prev_cmd_q;
  logic prev_chained_q;
  logic [127:0] pbuf_q;
  logic [4:0] pcnt_q;
  logic [4:0] pneed_q;
  logic ext_valid_q;
  logic ext_seen_q;
  logic [7:0] mask_q;
  logic [31:0] origin_q;
  logic [31:0] first_q;
  logic [31:0] last_q;
  logic loc_valid_q;
  subcmd_t sub_q;
  logic [15:0] count_q;
  logic [31:0] start_rba_q;
  logic [31:0] cur_rba_q;
  logic [15:0] blk_left_q;
  logic [`FBD_BLOCK_BYTES_W-1:0] byte_q;
  logic end_q;
  logic uc_q;
  logic seek_q;
  logic conn_q;
  logic feed_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic flush;
  logic in_push;
  logic ext_ok;
  logic loc_ok;
  logic [32:0] loc_last;
  logic cmd_take;
  subcmd_t loc_sub;
  cmd_t cmd_in;

  assign cmd_in = cmd_t'(cmd_code_i);
  assign cmd_take = cmd_valid_i && (state_q == ST_IDLE);
  assign loc_sub = subcmd_t'(pbuf_q[`FBD_LOC_SUB]);
  assign loc_last = {1'b0, pbuf_q[`FBD_LOC_START]} + 33'(pbuf_q[`FBD_LOC_COUNT]) - 33'd1;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks, evaluated once all bytes are in

  always_comb begin
    ext_ok = !ext_seen_q;
    if ((pbuf_q[`FBD_EXT_BSIZE] != `FBD_BLOCK_BYTES) && (pbuf_q[`FBD_EXT_BSIZE] != 16'h0000)) begin
      ext_ok = 1'b0;
    end
    if (pbuf_q[`FBD_EXT_FIRST] > pbuf_q[`FBD_EXT_LAST]) begin
      ext_ok = 1'b0;
    end
  end

  always_comb begin
    // Chained straight from extent setup or boot load read
    loc_ok = prev_chained_q && ext_valid_q
      && ((prev_cmd_q == CMD_EXTENT_SETUP) || (prev_cmd_q == CMD_BOOT_LOAD_READ));
    if (pbuf_q[`FBD_LOC_COUNT] == 16'h0000) begin
      loc_ok = 1'b0;
    end
    if ((pbuf_q[`FBD_LOC_START] < first_q) || (loc_last > {1'b0, last_q})) begin
      loc_ok = 1'b0;
    end
    case (loc_sub)
      SUB_READ_DATA, SUB_READ_REPLICATED: begin
      end
      SUB_WRITE_DATA, SUB_WRITE_CHECK: begin
        if (mask_q[`FBD_MASK_NO_WRITE]) begin
          loc_ok = 1'b0;
        end
      end
      SUB_FORMAT_DEFECT: begin
        if (mask_q[`FBD_MASK_NO_WRITE] || mask_q[`FBD_MASK_NO_FORMAT]) begin
          loc_ok = 1'b0;
        end
      end
      default: begin
        loc_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cur_cmd_q <= CMD_NOP;
      pneed_q <= '0;
      end_q <= 1'b0;
      uc_q <= 1'b0;
    end else begin
      end_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_take) begin
            cur_cmd_q <= cmd_in;
            uc_q <= 1'b0;
            case (cmd_in)
              CMD_EXTENT_SETUP: begin
                pneed_q <= `FBD_EXT_PARAM_BYTES;
                state_q <= ST_PARAM;
              end
              CMD_LOCATE: begin
                pneed_q <= `FBD_LOC_PARAM_BYTES;
                state_q <= ST_PARAM;
              end
              CMD_READ, CMD_WRITE: begin
                state_q <= ST_CHECK;
              end
              CMD_DIAG_CONTROL, CMD_DIAG_SENSE: begin
                uc_q <= ext_valid_q && command_chain_flag_i
                  && mask_q[`FBD_MASK_NO_DIAG];
                state_q <= ST_END;
              end
              default: begin
                state_q <= ST_END;
              end
            endcase
          end
        end
        ST_PARAM: begin
          if (param_valid_i && (pcnt_q == pneed_q - 5'd1)) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          case (cur_cmd_q)
            CMD_EXTENT_SETUP: begin
              uc_q <= !ext_ok;
              state_q <= ST_END;
            end
            CMD_LOCATE: begin
              if (loc_ok) begin
                state_q <= ST_SEEK;
              end else begin
                uc_q <= 1'b1;
                state_q <= ST_END;
              end
            end
            default: begin
              // Read or write must follow a matching positioning command
              if (!loc_valid_q || !prev_chained_q || (prev_cmd_q != CMD_LOCATE)
                  || (sub_q == SUB_FORMAT_DEFECT)
                  || ((cur_cmd_q == CMD_WRITE) != write_orient_o)) begin
                uc_q <= 1'b1;
                state_q <= ST_END;
              end else begin
                state_q <= ST_ID;
              end
            end
          endcase
        end
        ST_SEEK: begin
          if (seek_done_i) begin
            if (sub_q == SUB_FORMAT_DEFECT) begin
              uc_q <= !alt_avail_i;
            end
            state_q <= ST_END;
          end
        end
        ST_ID: begin
          if (id_valid_i) begin
            // Wrong location or bad check bytes abort the transfer
            if (id_ok_i && (id_rba_i == cur_rba_q)) begin
              state_q <= ST_DATA;
            end else begin
              uc_q <= 1'b1;
              state_q <= ST_END;
            end
          end
        end
        ST_DATA: begin
          if (in_push && (byte_q == `FBD_BLOCK_BYTES_W'(`FBD_BLOCK_BYTES - 16'h0001))) begin
            state_q <= (blk_left_q == 16'h0001) ? ST_DRAIN : ST_ID;
          end
        end
        ST_DRAIN: begin
          if (!fifo_out_valid) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          end_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter byte collection

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pbuf_q <= '0;
      pcnt_q <= '0;
    end else if (state_q == ST_IDLE) begin
      pcnt_q <= '0;
    end else if ((state_q == ST_PARAM) && param_valid_i) begin
      pbuf_q <= {pbuf_q[119:0], param_byte_i};
      pcnt_q <= pcnt_q + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program chaining history and saved extent

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_cmd_q <= CMD_NOP;
      prev_chained_q <= 1'b0;
      ext_valid_q <= 1'b0;
      ext_seen_q <= 1'b0;
      mask_q <= `FBD_MASK_RESET;
      origin_q <= `FBD_RBA_RESET;
      first_q <= `FBD_RBA_RESET;
      last_q <= `FBD_RBA_RESET;
    end else begin
      if (cmd_take) begin
        prev_chained_q <= command_chain_flag_i;
        if (!command_chain_flag_i) begin
          // An unchained command starts a new program and drops the old extent
          ext_valid_q <= 1'b0;
          ext_seen_q <= 1'b0;
          mask_q <= `FBD_MASK_RESET;
        end
      end
      if (end_q) begin
        prev_cmd_q <= cur_cmd_q;
      end
      if ((state_q == ST_CHECK) && (cur_cmd_q == CMD_EXTENT_SETUP)) begin
        ext_seen_q <= 1'b1;
        if (ext_ok) begin
          ext_valid_q <= 1'b1;
          mask_q <= pbuf_q[`FBD_EXT_MASK];
          origin_q <= pbuf_q[`FBD_EXT_ORIGIN];
          first_q <= pbuf_q[`FBD_EXT_FIRST];
          last_q <= pbuf_q[`FBD_EXT_LAST];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Positioning: subcommand, orientation and seek target

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loc_valid_q <= 1'b0;
      sub_q <= SUB_READ_DATA;
      count_q <= '0;
      start_rba_q <= `FBD_RBA_RESET;
    end else begin
      if (cmd_take && !command_chain_flag_i) begin
        loc_valid_q <= 1'b0;
      end else if ((state_q == ST_CHECK) && (cur_cmd_q == CMD_LOCATE)) begin
        loc_valid_q <= loc_ok;
        if (loc_ok) begin
          sub_q <= loc_sub;
          count_q <= pbuf_q[`FBD_LOC_COUNT];
          // Device block = extent origin + offset inside the extent
          start_rba_q <= origin_q + (pbuf_q[`FBD_LOC_START] - first_q);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seek_q <= 1'b0;
      conn_q <= 1'b1;
    end else begin
      // Extent setup never leaves ST_PARAM/ST_CHECK/ST_END, so stays connected
      seek_q <= (state_q == ST_CHECK) && (cur_cmd_q == CMD_LOCATE) && loc_ok;
      if ((state_q == ST_CHECK) && (cur_cmd_q == CMD_LOCATE) && loc_ok) begin
        conn_q <= 1'b0;
      end else if (state_q == ST_END) begin
        conn_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block and byte counting on the fill side

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_rba_q <= `FBD_RBA_RESET;
      blk_left_q <= '0;
      byte_q <= '0;
      feed_q <= 1'b0;
    end else begin
      if ((state_q == ST_CHECK) && (cur_cmd_q != CMD_LOCATE)
          && (cur_cmd_q != CMD_EXTENT_SETUP)) begin
        cur_rba_q <= start_rba_q;
        blk_left_q <= count_q;
        byte_q <= '0;
      end else if (in_push) begin
        if (byte_q == `FBD_BLOCK_BYTES_W'(`FBD_BLOCK_BYTES - 16'h0001)) begin
          byte_q <= '0;
          blk_left_q <= blk_left_q - 16'h0001;
          cur_rba_q <= cur_rba_q + 32'h0000_0001;
        end else begin
          byte_q <= byte_q + `FBD_BLOCK_BYTES_W'(1);
        end
      end
      feed_q <= (state_q == ST_ID) && id_valid_i && id_ok_i && (id_rba_i == cur_rba_q)
        || (state_q == ST_DATA) && !(in_push && (blk_left_q == 16'h0001)
        && (byte_q == `FBD_BLOCK_BYTES_W'(`FBD_BLOCK_BYTES - 16'h0001))
        ) && !(in_push && (byte_q == `FBD_BLOCK_BYTES_W'(`FBD_BLOCK_BYTES - 16'h0001)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path

  // Source is held off between blocks while the next identification is read
  assign in_push = feed_q && src_valid_i && fifo_in_ready;
  assign flush = (state_q == ST_IDLE);
  assign src_ready_o = feed_q && fifo_in_ready;

  fbd_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .in_valid_i(src_valid_i && feed_q),
    .in_data_i(src_data_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(snk_data_o),
    .out_ready_i(snk_ready_i)
  );

  assign snk_valid_o = fifo_out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmd_ready_o = (state_q == ST_IDLE);
  assign end_valid_o = end_q;
  assign unit_check_o = end_q && uc_q;
  assign connected_o = conn_q;
  assign seek_req_o = seek_q;
  assign seek_rba_o = start_rba_q;
  assign write_orient_o = (sub_q == SUB_WRITE_DATA) || (sub_q == SUB_WRITE_CHECK)
    || (sub_q == SUB_FORMAT_DEFECT);
  assign verify_o = (sub_q == SUB_WRITE_CHECK);
  assign replicated_o = (sub_q == SUB_READ_REPLICATED);
  assign service_area_o = mask_q[`FBD_MASK_SERVICE];
  assign feed_o = feed_q;

endmodule
`default_nettype wire

// [fbd_ctrl_monitor.sv]
/*
  Port-level checker for fbd_ctrl.
  Assumes it is bound to fbd_ctrl and sees only that module's ports.
*/
`default_nettype none

module fbd_ctrl_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic cmd_ready_o,
  input wire logic end_valid_o,
  input wire logic unit_check_o,
  input wire logic connected_o,
  input wire logic seek_req_o,
  input wire logic [31:0] seek_rba_o,
  input wire logic seek_done_i,
  input wire logic src_ready_o,
  input wire logic feed_o,
  input wire logic snk_valid_o,
  input wire logic [7:0] snk_data_o,
  input wire logic snk_ready_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_take_ext;
    cmd_valid_i && cmd_ready_o && cmd_code_i == 4'h0;
  endsequence
  sequence s_take_short;
    cmd_valid_i && cmd_ready_o && cmd_code_i inside {[4'h5:4'ha]};
  endsequence
  sequence s_done_seen;
    !connected_o && seek_done_i;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  a_check_with_end: assert property (unit_check_o |-> end_valid_o && connected_o)
    else $error("unit check outside an end pulse");
  a_end_one_cycle: assert property (end_valid_o |=> !end_valid_o)
    else $error("end pulse longer than one cycle");
  a_ext_stays_on: assert property (s_take_ext |=> connected_o [*8])
    else $error("disconnect during extent setup");
  a_short_end: assert property (s_take_short |-> ##2 end_valid_o)
    else $error("short command not ended two cycles after take");
  a_seek_off_line: assert property (seek_req_o |=> !connected_o)
    else $error("still connected after seek start");
  a_seek_end: assert property (s_done_seen |-> ##2 end_valid_o)
    else $error("positioning not ended two cycles after seek done");
  a_seek_no_take: assert property (!connected_o |-> !cmd_ready_o)
    else $error("command port open while disconnected");
  a_rba_steady: assert property (!connected_o && !$past(connected_o) |-> $stable(seek_rba_o))
    else $error("seek block moved during seek");
  a_feed_gate: assert property (src_ready_o |-> feed_o && connected_o)
    else $error("source accepted outside a block");
  a_sink_hold: assert property (snk_valid_o && !snk_ready_i |=> snk_valid_o && $stable(snk_data_o))
    else $error("sink byte dropped while stalled");
endmodule

bind fbd_ctrl fbd_ctrl_monitor i_mon (.sys_clk_i, .rst_n_i, .cmd_valid_i, .cmd_code_i,
  .cmd_ready_o, .end_valid_o, .unit_check_o, .connected_o, .seek_req_o, .seek_rba_o,
  .seek_done_i, .src_ready_o, .feed_o, .snk_valid_o, .snk_data_o, .snk_ready_i);

`default_nettype wire

// [fbd_disk_model.sv]
/*
  Disk positioner and formatter model facing fbd_ctrl.
  Assumes one clock shared with the controller; byte stream counts up.
*/
`default_nettype none

module fbd_disk_model #(
  parameter int SEEK_CYC = 12
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic seek_req_o,
  input wire logic [31:0] seek_rba_o,
  input wire logic feed_o,
  input wire logic src_ready_o,
  input wire logic alt_ok_i,
  output logic seek_done_i,
  output logic alt_avail_i,
  output logic id_valid_i,
  output logic id_ok_i,
  output logic [31:0] id_rba_i,
  output logic src_valid_i,
  output logic [7:0] src_data_i,
  output logic snk_ready_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] wait_q;
  logic [31:0] blk_q;
  logic [4:0] tick_q;
  logic feed_q;
  logic [7:0] byte_q;
  logic [5:0] stall_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 8'h00;
      seek_done_i <= 1'b0;
    end else begin
      seek_done_i <= (wait_q == 8'h01);
      if (seek_req_o) begin
        wait_q <= 8'(SEEK_CYC);
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end

  // Identification fields pass by every 32 cycles while no block is open
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_q <= 32'h0;
      tick_q <= 5'h00;
      feed_q <= 1'b0;
      id_valid_i <= 1'b0;
    end else begin
      feed_q <= feed_o;
      tick_q <= tick_q + 5'h01;
      id_valid_i <= !feed_o && tick_q == 5'h1f;
      if (seek_req_o) begin
        blk_q <= 32'h0;
      end else if (feed_q && !feed_o) begin
        blk_q <= blk_q + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_q <= 8'h00;
      stall_q <= 6'h00;
    end else begin
      stall_q <= stall_q + 6'h01;
      if (src_valid_i && src_ready_o) begin
        byte_q <= byte_q + 8'h01;
      end
    end
  end

  assign id_rba_i = seek_rba_o + blk_q;
  assign id_ok_i = 1'b1;
  assign alt_avail_i = alt_ok_i;
  assign src_valid_i = 1'b1;
  assign src_data_i = byte_q;
  // Stall a quarter of the time so the FIFO fills up
  assign snk_ready_i = stall_q[5:4] != 2'b00;
endmodule

`default_nettype wire

// [fbd_pkg.sv]
/*
  Types shared by the fixed-block disk command controller.
  Assumes fbd_regs.svh supplies the numeric constants.
*/
`default_nettype none
package fbd_pkg;

  // Sixteen command codes
  typedef enum logic [3:0] {
    CMD_EXTENT_SETUP = 4'h0,
    CMD_LOCATE = 4'h1,
    CMD_READ = 4'h2,
    CMD_WRITE = 4'h3,
    CMD_BOOT_LOAD_READ = 4'h4,
    CMD_DIAG_CONTROL = 4'h5,
    CMD_DIAG_SENSE = 4'h6,
    CMD_SENSE = 4'h7,
    CMD_READ_CHARS = 4'h8,
    CMD_READ_LOG = 4'h9,
    CMD_NOP = 4'ha,
    CMD_RSV_B = 4'hb,
    CMD_RSV_C = 4'hc,
    CMD_RSV_D = 4'hd,
    CMD_RSV_E = 4'he,
    CMD_RSV_F = 4'hf
  } cmd_t;

  typedef enum logic [3:0] {
    SUB_READ_DATA = 4'h0,
    SUB_READ_REPLICATED = 4'h1,
    SUB_WRITE_DATA = 4'h2,
    SUB_WRITE_CHECK = 4'h3,
    SUB_FORMAT_DEFECT = 4'h4
  } subcmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PARAM = 3'b001,
    ST_CHECK = 3'b010,
    ST_SEEK = 3'b011,
    ST_ID = 3'b100,
    ST_DATA = 3'b101,
    ST_DRAIN = 3'b110,
    ST_END = 3'b111
  } state_t;

endpackage
`default_nettype wire

// [fbd_regs.svh]
/*
  Constants of the fixed-block disk command controller: sizes, parameter byte
  layouts, mask bit positions and reset values.
  Assumes it is included by its bare name before any code that uses it.
*/
// What this block does
// - Data moves only as 512-byte blocks
// - Blocks addressed by linear number 0..N-1
// - One data command moves one or more blocks
// - Sector is identification field, gap, data field
// - Identification holds flags and physical location
// - Check bytes guard identification and data fields
// - Alternates assigned per block, placed anywhere
// - Sixteen commands; four cover normal transfers
// - Extent setup carries exactly sixteen parameter bytes
// - Mask inhibits writes and/or diagnostics
// - Defective-block format inhibited separately
// - Mask selects customer or service area
// - Block size 512 or zero meaning 512
// - Extent gives first, last, device origin
// - Valid extent kept until program ends
// - Stay connected during extent setup
// - Positioning carries eight parameter bytes
// - Block count at most 65,535
// - Five subcommands set read/write orientation
// - Disconnected while seeking to first block
// - Check extent bounds and mask before seek
`ifndef FBD_REGS_SVH
`define FBD_REGS_SVH

`define FBD_BLOCK_BYTES 16'h0200
`define FBD_BLOCK_BYTES_W 9
`define FBD_EXT_PARAM_BYTES 5'h10
`define FBD_LOC_PARAM_BYTES 5'h08
`define FBD_FIFO_DEPTH 8

// Extent parameter fields in the 128-bit shift buffer (byte 0 on top)
`define FBD_EXT_MASK 127:120
`define FBD_EXT_BSIZE 111:96
`define FBD_EXT_ORIGIN 95:64
`define FBD_EXT_FIRST 63:32
`define FBD_EXT_LAST 31:0

// Positioning parameter fields in the low 64 bits
`define FBD_LOC_SUB 59:56
`define FBD_LOC_COUNT 47:32
`define FBD_LOC_START 31:0

// Mask byte bits
`define FBD_MASK_NO_WRITE 7
`define FBD_MASK_NO_FORMAT 6
`define FBD_MASK_NO_DIAG 5
`define FBD_MASK_SERVICE 4

`define FBD_MASK_RESET 8'h00
`define FBD_RBA_RESET 32'h0000_0000

`endif

// [tb_fixed_block_disk_command_control.sv]
/*
  Self-checking bench for fbd_ctrl: channel side from tasks, disk side
  from fbd_disk_model. Assumes design, monitor and model compile first.
*/
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_fixed_block_disk_command_control;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic command_chain_flag_i = 1'b0;
  logic param_valid_i = 1'b0;
  logic alt_ok_i = 1'b1;
  logic [3:0] cmd_code_i = 4'h0;
  logic [7:0] param_byte_i = 8'h00;
  logic cmd_ready_o, end_valid_o, unit_check_o, connected_o, seek_req_o, seek_done_i;
  logic alt_avail_i, id_valid_i, id_ok_i, src_valid_i, src_ready_o, snk_valid_o, snk_ready_i;
  logic write_orient_o, verify_o, replicated_o, service_area_o, feed_o;
  logic [31:0] seek_rba_o, id_rba_i, rba_cap;
  logic [7:0] src_data_i, snk_data_o;
  logic [7:0] exp_byte = 8'h00;
  logic last_uc = 1'b0;
  logic disc_seen = 1'b0;
  logic full_seen = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  int seek_cnt = 0;
  int nbytes = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  fbd_ctrl i_dut (.*);
  fbd_disk_model i_disk (.*);

  always @(posedge sys_clk_i) begin
    if (!connected_o) disc_seen <= 1'b1;
    if (feed_o && !src_ready_o) full_seen <= 1'b1;
    if (seek_req_o) begin
      seek_cnt <= seek_cnt + 1;
      rba_cap <= seek_rba_o;
    end
    if (snk_valid_o && snk_ready_i) begin
      `CHK(snk_data_o, exp_byte)
      exp_byte <= exp_byte + 8'h01;
      nbytes <= nbytes + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk_i);
    #2;
  endtask

  // Parameter bytes leave from the top of v, byte 0 first
  task automatic send(input logic [3:0] code, input logic chain, input int n,
                      input logic [127:0] v);
    int i;
    tick();
    for (i = 0; i < 50 && cmd_ready_o !== 1'b1; i++) tick();
    if (i == 50) begin
      n_fail++;
      close_out();
    end
    cmd_valid_i = 1'b1;
    cmd_code_i = code;
    command_chain_flag_i = chain;
    tick();
    cmd_valid_i = 1'b0;
    for (i = 0; i < n; i++) begin
      param_valid_i = 1'b1;
      param_byte_i = v[127 - 8 * i -: 8];
      tick();
    end
    param_valid_i = 1'b0;
    for (i = 0; i < 9000 && end_valid_o !== 1'b1; i++) tick();
    if (i == 9000) begin
      n_fail++;
      close_out();
    end
    last_uc = unit_check_o;
  endtask

  // Extent: blocks 200..299 of the data set, first one at device block 999
  task automatic ext(input logic [7:0] mask, input logic [15:0] bsize, input logic chain);
    disc_seen = 1'b0;
    send(4'h0, chain, 16, {mask, 8'h00, bsize, 32'h3e7, 32'hc8, 32'h12b});
  endtask

  task automatic loc(input logic [3:0] sub, input logic [15:0] cnt, input logic [31:0] start,
                     input logic chain);
    disc_seen = 1'b0;
    send(4'h1, chain, 8, {4'h0, sub, 8'h00, cnt, start, 64'h0});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    `CHK({cmd_ready_o, connected_o}, 2'b11)
    `CHK({end_valid_o, seek_req_o, snk_valid_o, src_ready_o, write_orient_o}, 5'h00)
    `CHK(seek_rba_o, 32'h0000_0000)
  endtask

  task automatic sc_read();
    ext(8'h10, 16'h0000, 1'b0);
    `CHK({last_uc, disc_seen, service_area_o}, 3'b001)
    loc(4'h1, 16'h0002, 32'h0000_00ca, 1'b1);
    `CHK({last_uc, disc_seen, replicated_o, write_orient_o}, 4'b0110)
    `CHK(rba_cap, 32'h0000_03e9)
    nbytes = 0;
    full_seen = 1'b0;
    send(4'h2, 1'b1, 0, 128'h0);
    `CHK({last_uc, full_seen}, 2'b01)
    `CHK(nbytes, 1024)
  endtask

  task automatic sc_write();
    ext(8'h00, 16'h0200, 1'b0);
    loc(4'h3, 16'h0001, 32'h0000_012b, 1'b1);
    `CHK({last_uc, write_orient_o, verify_o, replicated_o}, 4'b0110)
    `CHK(rba_cap, 32'h0000_044a)
    nbytes = 0;
    send(4'h3, 1'b1, 0, 128'h0);
    `CHK(last_uc, 1'b0)
    `CHK(nbytes, 512)
  endtask

  // Just below the first and one past the last block of the extent
  task automatic sc_bounds();
    int k;
    int s;
    for (k = 0; k < 2; k++) begin
      s = seek_cnt;
      ext(8'h00, 16'h0200, 1'b0);
      loc(4'h0, k ? 16'h0002 : 16'h0001, k ? 32'h12b : 32'hc7, 1'b1);
      `CHK({last_uc, seek_cnt == s}, 2'b11)
    end
  endtask

  task automatic sc_mask();
    logic [7:0] m [6] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h00, 8'h00};
    logic [3:0] sb [6] = '{4'h2, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4};
    logic [5:0] alt = 6'b011111;
    logic [5:0] uc_exp = 6'b100111;
    int k;
    for (k = 0; k < 6; k++) begin
      alt_ok_i = alt[k];
      ext(m[k], 16'h0200, 1'b0);
      loc(sb[k], 16'h0001, 32'h0000_00c8, 1'b1);
      `CHK(last_uc, uc_exp[k])
    end
    alt_ok_i = 1'b1;
  endtask

  task automatic sc_order();
    send(4'h2, 1'b0, 0, 128'h0);
    `CHK(last_uc, 1'b1)
    ext(8'h00, 16'h0200, 1'b0);
    ext(8'h00, 16'h0200, 1'b1);
    `CHK(last_uc, 1'b1)
    loc(4'h0, 16'h0001, 32'h0000_00c8, 1'b0);
    `CHK(last_uc, 1'b1)
    ext(8'h00, 16'h0300, 1'b0);
    `CHK(last_uc, 1'b1)
    ext(8'h20, 16'h0200, 1'b0);
    send(4'h5, 1'b1, 0, 128'h0);
    `CHK(last_uc, 1'b1)
    ext(8'h00, 16'h0200, 1'b0);
    send(4'h5, 1'b1, 0, 128'h0);
    `CHK(last_uc, 1'b0)
    ext(8'h00, 16'h0200, 1'b0);
    loc(4'h0, 16'h0001, 32'h0000_00c8, 1'b1);
    send(4'h3, 1'b1, 0, 128'h0);
    `CHK(last_uc, 1'b1)
    ext(8'h00, 16'h0200, 1'b0);
    send(4'h4, 1'b1, 0, 128'h0);
    loc(4'h0, 16'h0001, 32'h0000_00c8, 1'b1);
    `CHK({last_uc, disc_seen}, 2'b01)
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    #2;
    sc_reset();
    rst_n_i = 1'b1;
    sc_read();
    sc_write();
    sc_bounds();
    sc_mask();
    sc_order();
    close_out();
  end
endmodule

`default_nettype wire
